/* bridge_cfg_pkg.sv */
// constants, field positions and resets of the bridge command front end
//
// Behaviour
// - vendor word is a fixed 16-bit read-only value; writes do nothing
// - device word is a fixed 16-bit read-only value; writes do nothing
// - io space enable bit 0, reset zero, gates claiming of primary io window hits
// - memory space enable bit 1 gates claiming of memory and prefetch window hits
// - forwarding enable bit 2 low blocks upstream memory, io and msi writes
// - forwarding disabled: non-posted downstream-originated memory and io requests get unsupported request
// - forwarding enable never blocks completions nor non memory/io requests
// - master parity flag sets only with poison enable bit 6 on poison event
// - fatal/nonfatal errors reported when system error enable bit 8 or device enables set
// - system error enable lets fatal and nonfatal messages pass secondary to primary
// - correctable error messages always pass secondary to primary
// - legacy interrupt disable bit 10 negates the bridge's own interrupt
// - legacy interrupt disable leaves forwarded secondary interrupts untouched
// - command bits 3,4,5,7,9 and 15:11 read zero and ignore writes
// - master parity flag sits at status bit 8, cleared by writing one
package bridge_cfg_pkg;
	// ==========================================================
	// configuration offsets
	localparam logic [11:0] VENDOR_ID_OFS = 12'h000;
	localparam logic [11:0] DEVICE_ID_OFS = 12'h002;
	localparam logic [11:0] COMMAND_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h006;
	// ==========================================================
	// identity values, arbitrary
	localparam logic [15:0] VENDOR_ID_VAL = 16'hA5A5;
	localparam logic [15:0] DEVICE_ID_VAL = 16'h5A01;
	// ==========================================================
	// command field positions
	localparam int IO_EN_BIT = 0;
	localparam int MEM_EN_BIT = 1;
	localparam int FWD_EN_BIT = 2;
	localparam int POISON_EN_BIT = 6;
	localparam int SERR_EN_BIT = 8;
	localparam int IRQ_DIS_BIT = 10;
	localparam logic [15:0] COMMAND_WMASK = 16'h0547;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	// ==========================================================
	// status field positions
	localparam int MPAR_BIT = 8;
	localparam logic MPAR_RESET = 1'b0;
	// ==========================================================
	// request classes seen at the bridge
	typedef enum logic [2:0] {
		REQ_MEM = 3'h0,
		REQ_IO = 3'h1,
		REQ_MSG = 3'h2,
		REQ_CPL = 3'h3,
		REQ_CFG = 3'h4
	} req_class_t;
	// error message classes from the secondary side
	typedef enum logic [1:0] {
		MSG_COR = 2'h0,
		MSG_NONFATAL = 2'h1,
		MSG_FATAL = 2'h2
	} err_msg_t;
	// ==========================================================
	// config access state machine
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b100
	} cfg_state_t;
endpackage

/* bridge_req_gate.sv */
// request gating of the bridge: window claims and upstream forwarding
module bridge_req_gate (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic io_space_enable,
	input wire logic memory_space_enable,
	input wire logic request_forwarding_enable,
	input wire logic pri_req_valid,
	input wire logic [2:0] pri_req_class,
	input wire logic pri_io_hit,
	input wire logic pri_mem_hit,
	input wire logic pri_pref_hit,
	input wire logic sec_req_valid,
	input wire logic [2:0] sec_req_class,
	input wire logic sec_req_nonposted,
	output logic pri_claim_r,
	output logic sec_forward_r,
	output logic sec_ur_cpl_r
);
	// ==========================================================
	// gating decode
	logic is_memio;
	logic claim_nxt;
	logic fwd_nxt;
	logic ur_nxt;

	// classify and decide one cycle ahead of the registered answer
	always_comb begin
		is_memio = (sec_req_class == bridge_cfg_pkg::REQ_MEM) ||
			(sec_req_class == bridge_cfg_pkg::REQ_IO);
		claim_nxt = pri_req_valid && (
			(pri_req_class == bridge_cfg_pkg::REQ_IO && pri_io_hit &&
				io_space_enable) ||
			(pri_req_class == bridge_cfg_pkg::REQ_MEM &&
				(pri_mem_hit || pri_pref_hit) && memory_space_enable));
		fwd_nxt = sec_req_valid && (!is_memio || request_forwarding_enable);
		ur_nxt = sec_req_valid && is_memio && !request_forwarding_enable &&
			sec_req_nonposted;
	end

	// registered gating outputs
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pri_claim_r <= 1'b0;
			sec_forward_r <= 1'b0;
			sec_ur_cpl_r <= 1'b0;
		end else if (clk_en) begin
			pri_claim_r <= claim_nxt;
			sec_forward_r <= fwd_nxt;
			sec_ur_cpl_r <= ur_nxt;
		end
	end
endmodule

/* bridge_err_irq.sv */
// error message forwarding, error reporting and legacy interrupt gating
module bridge_err_irq (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic system_error_enable,
	input wire logic legacy_irq_disable,
	input wire logic dev_ctl_err_en,
	input wire logic err_detect,
	input wire logic sec_msg_valid,
	input wire logic [1:0] sec_msg_class,
	input wire logic own_irq_req,
	input wire logic sec_irq_in,
	output logic pri_msg_fwd_r,
	output logic err_report_r,
	output logic own_irq_r,
	output logic pri_irq_fwd_r
);
	// ==========================================================
	// registered error and interrupt outputs
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pri_msg_fwd_r <= 1'b0;
			err_report_r <= 1'b0;
			own_irq_r <= 1'b0;
			pri_irq_fwd_r <= 1'b0;
		end else if (clk_en) begin
			pri_msg_fwd_r <= sec_msg_valid && ((sec_msg_class == bridge_cfg_pkg::MSG_COR) ||
				system_error_enable);
			err_report_r <= err_detect && (system_error_enable || dev_ctl_err_en);
			own_irq_r <= own_irq_req && !legacy_irq_disable;
			pri_irq_fwd_r <= sec_irq_in;
		end
	end
endmodule

/* bridge_command_id_regs.sv */
// bridge identity words, command register and master parity status flag
module bridge_command_id_regs #(
	parameter logic [15:0] VENDOR_ID = bridge_cfg_pkg::VENDOR_ID_VAL,
	parameter logic [15:0] DEVICE_ID = bridge_cfg_pkg::DEVICE_ID_VAL
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// configuration access, 16-bit word wide
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [11:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	input wire logic [1:0] cfg_be,
	output logic [15:0] cfg_rdata_r,
	output logic cfg_ack_r,
	// primary side requests
	input wire logic pri_req_valid,
	input wire logic [2:0] pri_req_class,
	input wire logic pri_io_hit,
	input wire logic pri_mem_hit,
	input wire logic pri_pref_hit,
	output logic pri_claim_r,
	// secondary side requests
	input wire logic sec_req_valid,
	input wire logic [2:0] sec_req_class,
	input wire logic sec_req_nonposted,
	output logic sec_forward_r,
	output logic sec_ur_cpl_r,
	// poison events on the primary side
	input wire logic poison_cpl_rx,
	input wire logic poison_wr_tx,
	// errors and messages
	input wire logic dev_ctl_err_en,
	input wire logic err_detect,
	input wire logic sec_msg_valid,
	input wire logic [1:0] sec_msg_class,
	output logic pri_msg_fwd_r,
	output logic err_report_r,
	// interrupts
	input wire logic own_irq_req,
	input wire logic sec_irq_in,
	output logic own_irq_r,
	output logic pri_irq_fwd_r,
	// control levels for the rest of the port
	output logic [15:0] command_r
);
	// ==========================================================
	// state and decode
	bridge_cfg_pkg::cfg_state_t state_r;
	bridge_cfg_pkg::cfg_state_t state_nxt;
	logic mpar_r;
	logic [15:0] wr_mask;
	logic [15:0] rd_word;

	// byte lane expansion, used by the command register write; the parity flag clear tests cfg_be[1] directly
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// register select by word address
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
		addr_is = (a[11:1] == ofs[11:1]);
	endfunction

	// ==========================================================
	// access sequencing: one cycle to take, one to answer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bridge_cfg_pkg::ST_IDLE: begin
				if (cfg_wr) begin
					state_nxt = bridge_cfg_pkg::ST_WRITE;
				end else if (cfg_rd) begin
					state_nxt = bridge_cfg_pkg::ST_READ;
				end
			end
			bridge_cfg_pkg::ST_WRITE: state_nxt = bridge_cfg_pkg::ST_IDLE;
			bridge_cfg_pkg::ST_READ: state_nxt = bridge_cfg_pkg::ST_IDLE;
			default: state_nxt = bridge_cfg_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= bridge_cfg_pkg::ST_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// write mask for the taken access
	always_comb begin
		wr_mask = lane_mask(cfg_be);
	end

	// ==========================================================
	// command register; only the documented writable bits store
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			command_r <= bridge_cfg_pkg::COMMAND_RESET;
		end else if (clk_en && state_r == bridge_cfg_pkg::ST_IDLE && cfg_wr &&
			addr_is(cfg_addr, bridge_cfg_pkg::COMMAND_OFS)) begin
			command_r <= (command_r & ~(wr_mask & bridge_cfg_pkg::COMMAND_WMASK)) |
				(cfg_wdata & wr_mask & bridge_cfg_pkg::COMMAND_WMASK);
		end
	end

	// ==========================================================
	// master parity flag: event set wins over write-one clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mpar_r <= bridge_cfg_pkg::MPAR_RESET;
		end else if (clk_en) begin
			if (command_r[bridge_cfg_pkg::POISON_EN_BIT] && (poison_cpl_rx || poison_wr_tx)) begin
				mpar_r <= 1'b1;
			end else if (state_r == bridge_cfg_pkg::ST_IDLE && cfg_wr &&
				addr_is(cfg_addr, bridge_cfg_pkg::STATUS_OFS) && cfg_be[1] &&
				cfg_wdata[bridge_cfg_pkg::MPAR_BIT]) begin
				mpar_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read mux; unmapped words read zero
	always_comb begin
		rd_word = 16'h0000;
		if (addr_is(cfg_addr, bridge_cfg_pkg::VENDOR_ID_OFS)) begin
			rd_word = VENDOR_ID;
		end else if (addr_is(cfg_addr, bridge_cfg_pkg::DEVICE_ID_OFS)) begin
			rd_word = DEVICE_ID;
		end else if (addr_is(cfg_addr, bridge_cfg_pkg::COMMAND_OFS)) begin
			rd_word = command_r & bridge_cfg_pkg::COMMAND_WMASK;
		end else if (addr_is(cfg_addr, bridge_cfg_pkg::STATUS_OFS)) begin
			rd_word[bridge_cfg_pkg::MPAR_BIT] = mpar_r;
		end
	end

	// read data and acknowledge, registered
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_rdata_r <= 16'h0000;
			cfg_ack_r <= 1'b0;
		end else if (clk_en) begin
			cfg_ack_r <= (state_r == bridge_cfg_pkg::ST_IDLE) && (cfg_rd || cfg_wr);
			if (state_r == bridge_cfg_pkg::ST_IDLE && cfg_rd && !cfg_wr) begin
				cfg_rdata_r <= rd_word;
			end
		end
	end

	// ==========================================================
	// request gating
	bridge_req_gate u_req_gate (
		.core_clk(core_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.io_space_enable(command_r[bridge_cfg_pkg::IO_EN_BIT]),
		.memory_space_enable(command_r[bridge_cfg_pkg::MEM_EN_BIT]),
		.request_forwarding_enable(command_r[bridge_cfg_pkg::FWD_EN_BIT]),
		.pri_req_valid(pri_req_valid),
		.pri_req_class(pri_req_class),
		.pri_io_hit(pri_io_hit),
		.pri_mem_hit(pri_mem_hit),
		.pri_pref_hit(pri_pref_hit),
		.sec_req_valid(sec_req_valid),
		.sec_req_class(sec_req_class),
		.sec_req_nonposted(sec_req_nonposted),
		.pri_claim_r(pri_claim_r),
		.sec_forward_r(sec_forward_r),
		.sec_ur_cpl_r(sec_ur_cpl_r)
	);

	// error messages and interrupts
	bridge_err_irq u_err_irq (
		.core_clk(core_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.system_error_enable(command_r[bridge_cfg_pkg::SERR_EN_BIT]),
		.legacy_irq_disable(command_r[bridge_cfg_pkg::IRQ_DIS_BIT]),
		.dev_ctl_err_en(dev_ctl_err_en),
		.err_detect(err_detect),
		.sec_msg_valid(sec_msg_valid),
		.sec_msg_class(sec_msg_class),
		.own_irq_req(own_irq_req),
		.sec_irq_in(sec_irq_in),
		.pri_msg_fwd_r(pri_msg_fwd_r),
		.err_report_r(err_report_r),
		.own_irq_r(own_irq_r),
		.pri_irq_fwd_r(pri_irq_fwd_r)
	);
endmodule

/* bridge_cmd_props.sv */
// port assertions of the bridge command front end
module bridge_cmd_props (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic cfg_ack_r,
	input wire logic pri_req_valid,
	input wire logic [2:0] pri_req_class,
	input wire logic pri_io_hit,
	input wire logic pri_mem_hit,
	input wire logic pri_pref_hit,
	input wire logic pri_claim_r,
	input wire logic sec_req_valid,
	input wire logic [2:0] sec_req_class,
	input wire logic sec_req_nonposted,
	input wire logic sec_forward_r,
	input wire logic sec_ur_cpl_r,
	input wire logic dev_ctl_err_en,
	input wire logic err_detect,
	input wire logic sec_msg_valid,
	input wire logic [1:0] sec_msg_class,
	input wire logic pri_msg_fwd_r,
	input wire logic err_report_r,
	input wire logic own_irq_req,
	input wire logic sec_irq_in,
	input wire logic own_irq_r,
	input wire logic pri_irq_fwd_r,
	input wire logic [15:0] command_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// config handshake: a taken access gets exactly one ack pulse
	sequence s_take;
		(cfg_rd || cfg_wr) && clk_en && !cfg_ack_r;
	endsequence
	sequence s_ack_once;
		##1 cfg_ack_r ##1 !cfg_ack_r;
	endsequence
	a_cfg_ack_pulse: assert property (s_take |-> s_ack_once) else $error("ack not one pulse");
	// ==========================================================
	// request, message, error and interrupt gating one cycle later; fixed command bits stay zero
	a_io_claim_gate: assert property (clk_en && pri_req_valid && pri_io_hit &&
		pri_req_class == bridge_cfg_pkg::REQ_IO |=> pri_claim_r == $past(command_r[0]))
		else $error("io claim not gated");
	a_mem_claim_gate: assert property (clk_en && pri_req_valid && (pri_mem_hit || pri_pref_hit)
		&& pri_req_class == bridge_cfg_pkg::REQ_MEM |=> pri_claim_r == $past(command_r[1]))
		else $error("memory claim not gated");
	a_claim_miss_none: assert property (clk_en && !(pri_req_valid && pri_io_hit &&
		pri_req_class == bridge_cfg_pkg::REQ_IO) && !(pri_req_valid && (pri_mem_hit || pri_pref_hit)
		&& pri_req_class == bridge_cfg_pkg::REQ_MEM) |=> !pri_claim_r)
		else $error("claim without window hit");
	a_fwd_mem_io: assert property (clk_en && sec_req_valid && sec_req_class < 3'h2 |=>
		sec_forward_r == $past(command_r[2]) && sec_ur_cpl_r == (!$past(command_r[2])
		&& $past(sec_req_nonposted))) else $error("upstream forwarding wrong");
	a_fwd_other_pass: assert property (clk_en && sec_req_valid && sec_req_class > 3'h1 |=>
		sec_forward_r && !sec_ur_cpl_r) else $error("other request blocked");
	a_msg_fwd_gate: assert property (clk_en && sec_msg_valid |=> pri_msg_fwd_r ==
		($past(sec_msg_class) == bridge_cfg_pkg::MSG_COR || $past(command_r[8])))
		else $error("error message forwarding wrong");
	a_err_report_gate: assert property (clk_en |=> err_report_r == ($past(err_detect) &&
		($past(command_r[8]) || $past(dev_ctl_err_en)))) else $error("error report wrong");
	a_own_irq_mask: assert property (clk_en |=> own_irq_r == ($past(own_irq_req) &&
		!$past(command_r[10]))) else $error("own interrupt not masked");
	a_sec_irq_pass: assert property (clk_en |=> pri_irq_fwd_r == $past(sec_irq_in))
		else $error("forwarded interrupt altered");
	a_cmd_fixed_bits: assert property ((command_r & ~bridge_cfg_pkg::COMMAND_WMASK) == 16'h0000)
		else $error("fixed command bits set");
endmodule

/* cfg_host_model.sv */
// configuration requester on the root complex side
module cfg_host_model (
	input wire logic core_clk,
	input wire logic cfg_ack_r,
	output logic cfg_rd,
	output logic cfg_wr,
	output logic [11:0] cfg_addr,
	output logic [15:0] cfg_wdata,
	output logic [1:0] cfg_be
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle until the first access
	initial begin
		{cfg_rd, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = '0;
	end
	// one access held until the ack edge, then released with inverted lines
	task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] d,
		input logic [1:0] be, output logic ok);
		ok = 1'b0;
		@(negedge core_clk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {wr, !wr, a, d, be};
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge core_clk);
			ok = (cfg_ack_r === 1'b1);
		end
		@(negedge core_clk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {2'h0, ~a, ~d, ~be};
	endtask
endmodule

/* bridge_command_id_regs_tb_top.sv */
// self-checking bench of the bridge command front end
module bridge_command_id_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rstn = 1'b0, clk_en, cfg_rd, cfg_wr, cfg_ack_r, ok;
	logic [11:0] cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata_r, command_r;
	logic [1:0] cfg_be, sec_msg_class;
	logic [2:0] pri_req_class, sec_req_class;
	logic pri_req_valid, pri_io_hit, pri_mem_hit, pri_pref_hit, pri_claim_r, sec_req_valid;
	logic sec_req_nonposted, sec_forward_r, sec_ur_cpl_r, poison_cpl_rx, poison_wr_tx;
	logic dev_ctl_err_en, err_detect, sec_msg_valid, pri_msg_fwd_r, err_report_r;
	logic own_irq_req, sec_irq_in, own_irq_r, pri_irq_fwd_r;
	logic [16:0] exp_q[$];
	logic [16:0] note;
	logic [6:0] gate_q[$];
	logic [6:0] gexp, gnote, gate_out;
	logic gate_pend = 1'b0;
	logic [15:0] cmds[4] = '{16'h0000, 16'h0547, 16'h0105, 16'h0442};
	int fails = 0, comparisons = 0;
	// ==========================================================
	// clock, design and requester
	always #4 core_clk = ~core_clk;
	bridge_command_id_regs bridge_command_id_regs_inst (.*);
	cfg_host_model cfg_host_model_inst (.*);
	// gating outputs packed in the order of the expectation notes
	assign gate_out = {pri_claim_r, sec_forward_r, sec_ur_cpl_r, pri_msg_fwd_r, err_report_r,
		own_irq_r, pri_irq_fwd_r};
	// ==========================================================
	// report and compare
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_gate(input logic [6:0] got, input logic [6:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t gating %b expected %b", $time, got, exp);
		end
	endtask
	// one access; the note carries a compare flag and the expected read
	task automatic cfg(input logic wr, input logic [11:0] a, input logic [15:0] d,
		input logic [1:0] be, input logic chk);
		exp_q.push_back({chk, d});
		cfg_host_model_inst.access(wr, a, d, be, ok);
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t no ack", $time);
			complete_run();
		end
	endtask
	task automatic poison(input logic c, input logic w);
		@(negedge core_clk);
		{poison_cpl_rx, poison_wr_tx} = {c, w};
		@(negedge core_clk);
		{poison_cpl_rx, poison_wr_tx} = 2'h0;
	endtask
	// takes the oldest note at every ack and checks reads
	always @(posedge core_clk) begin
		if (cfg_ack_r === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("ERROR %0t ack without access", $time);
			end else begin
				note = exp_q.pop_front();
				if (note[16]) cmp16(cfg_rdata_r, note[15:0]);
			end
		end
	end
	// gating: a note for a taking edge is compared at the edge after it
	always @(posedge core_clk) begin
		if (gate_pend) begin
			gnote = gate_q.pop_front();
			cmp_gate(gate_out, gnote);
		end
		gate_pend = (gate_q.size() > 0);
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		complete_run();
	end
	// ==========================================================
	// main sequence
	initial begin
		{clk_en, pri_req_valid, pri_req_class, pri_io_hit, pri_mem_hit, pri_pref_hit} = '0;
		{sec_req_valid, sec_req_class, sec_req_nonposted, poison_cpl_rx, poison_wr_tx} = '0;
		{dev_ctl_err_en, err_detect, sec_msg_valid, sec_msg_class, own_irq_req, sec_irq_in} = '0;
		void'($urandom(32'h49038BB6));
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		clk_en = 1'b1;
		// identity and reset values, then writes that must change nothing
		for (int i = 0; i < 2; i++) begin
			cfg(1'b0, 12'h000, bridge_cfg_pkg::VENDOR_ID_VAL, 2'h3, 1'b1);
			cfg(1'b0, 12'h002, bridge_cfg_pkg::DEVICE_ID_VAL, 2'h3, 1'b1);
			cfg(1'b0, 12'h004, 16'h0000, 2'h3, 1'b1);
			cfg(1'b0, 12'h006, 16'h0000, 2'h3, 1'b1);
			cfg(1'b1, 12'h000, 16'hFFFF, 2'h3, 1'b0);
			cfg(1'b1, 12'h002, 16'hFFFF, 2'h3, 1'b0);
			cfg(1'b1, 12'h010, 16'hFFFF, 2'h3, 1'b0);
		end
		// writable mask under byte enables
		cfg(1'b1, 12'h004, 16'hFFFF, 2'h1, 1'b0);
		cfg(1'b0, 12'h004, 16'h0047, 2'h3, 1'b1);
		cfg(1'b1, 12'h004, 16'hFFFF, 2'h3, 1'b0);
		cfg(1'b0, 12'h004, 16'h0547, 2'h3, 1'b1);
		// random traffic under several command settings
		foreach (cmds[k]) begin
			cfg(1'b1, 12'h004, cmds[k], 2'h3, 1'b0);
			repeat (60) begin
				@(negedge core_clk);
				{pri_req_valid, pri_io_hit, pri_mem_hit, pri_pref_hit, sec_req_valid} = 5'($urandom());
				{sec_req_nonposted, err_detect, dev_ctl_err_en, sec_msg_valid} = 4'($urandom());
				{own_irq_req, sec_irq_in} = 2'($urandom());
				pri_req_class = 3'($urandom_range(4, 0));
				sec_req_class = 3'($urandom_range(4, 0));
				sec_msg_class = 2'($urandom_range(2, 0));
				clk_en = ($urandom_range(7, 0) != 0);
				// expected gating answer from the command bits now in force
				gexp[6] = pri_req_valid && ((pri_req_class == 3'h1 && pri_io_hit && cmds[k][0]) ||
					(pri_req_class == 3'h0 && (pri_mem_hit || pri_pref_hit) && cmds[k][1]));
				gexp[5] = sec_req_valid && (sec_req_class > 3'h1 || cmds[k][2]);
				gexp[4] = sec_req_valid && sec_req_class < 3'h2 && !cmds[k][2] && sec_req_nonposted;
				gexp[3] = sec_msg_valid && (sec_msg_class == 2'h0 || cmds[k][8]);
				gexp[2] = err_detect && (cmds[k][8] || dev_ctl_err_en);
				gexp[1] = own_irq_req && !cmds[k][10];
				gexp[0] = sec_irq_in;
				if (clk_en) gate_q.push_back(gexp);
			end
			@(negedge core_clk);
			clk_en = 1'b1;
		end
		// poison flag needs reporting enabled and clears on a high-byte one
		cfg(1'b1, 12'h004, 16'h0000, 2'h3, 1'b0);
		poison(1'b1, 1'b0);
		cfg(1'b0, 12'h006, 16'h0000, 2'h3, 1'b1);
		cfg(1'b1, 12'h004, 16'h0040, 2'h3, 1'b0);
		poison(1'b0, 1'b1);
		cfg(1'b0, 12'h006, 16'h0100, 2'h3, 1'b1);
		cfg(1'b1, 12'h006, 16'h0100, 2'h1, 1'b0);
		cfg(1'b0, 12'h006, 16'h0100, 2'h3, 1'b1);
		cfg(1'b1, 12'h006, 16'h0100, 2'h3, 1'b0);
		cfg(1'b0, 12'h006, 16'h0000, 2'h3, 1'b1);
		poison(1'b1, 1'b0);
		cfg(1'b0, 12'h006, 16'h0100, 2'h3, 1'b1);
		// reset in mid-run clears the command word
		cfg(1'b1, 12'h004, 16'h0547, 2'h3, 1'b0);
		@(negedge core_clk);
		rstn = 1'b0;
		repeat (2) @(negedge core_clk);
		rstn = 1'b1;
		cfg(1'b0, 12'h004, 16'h0000, 2'h3, 1'b1);
		cfg(1'b0, 12'h006, 16'h0000, 2'h3, 1'b1);
		complete_run();
	end
endmodule
bind bridge_command_id_regs bridge_cmd_props bridge_cmd_props_inst (.*);
